// file: design/ghl_defines.svh
/*
 * Timing figures, counter widths and idle levels for the gauge host-link
 * timing block. Definitions only; included by the package and the modules.
 */
`ifndef GHL_DEFINES_SVH
`define GHL_DEFINES_SVH

// system clock and the slow tick that paces the millisecond counters
`define GHL_CLK_HZ        10000000
`define GHL_TICK_HZ       1000

// counter widths
`define GHL_MS_W          15
`define GHL_CYC_W         12
`define GHL_TICK_W        14

// smbus figures
`define GHL_SLV_FMAX_KHZ  100
`define GHL_SLV_FMIN_KHZ  10
`define GHL_MST_HZ        51200
`define GHL_TOUT_MS       30
`define GHL_IDLE_RST_MS   50
`define GHL_IDLE_US       50
`define GHL_SEXT_MS       25
`define GHL_MEXT_MS       10

// single-wire figures
`define GHL_SW_START_US   32
`define GHL_SW_B0_US      120
`define GHL_SW_CELL_US    205
`define GHL_SW_RSP_US     200
`define GHL_SW_RXS_US     100

// measurement schedule
`define GHL_MEAS_BASE_MS  2000
`define GHL_MEAS_MAX_MS   2500
`define GHL_FC_ADD_MS     500
`define GHL_FC_PER_MS     20000

// released open-drain line level
`define GHL_LINE_IDLE     1'b1

`endif

// file: design/ghl_link_timing.sv
/*
 * Host-link timing for a battery gauge: smbus clock supervision, master
 * clock, stretch budgets, single-wire bit cells and the measurement schedule.
 * Assumes open-drain pins resolved outside and a core driving the requests.
 */
// Function
// - slave bus clock between 10 and 100 kHz; only a clock faster than 100 kHz is flagged
// - master clock nominal 51.2 kHz
// - clock low too long gives timeout, abort
// - clock high over 50 ms resets transaction
// - idle only after 50 us high
// - slave stretch total per message within 25 ms
// - master stretch total per message within 10 ms
// - sent bit cells last 190 to 250 us
// - sent start low pulse at least 32 us
// - read data starts 190 to 320 us later
// - measurement cycle every 2 to 2.5 s
// - longest interval with all three slow modes
// - rate forecast adds at most 0.5 s
`timescale 1ns/1ns
`default_nettype none
`include "ghl_defines.svh"

module ghl_link_timing #(
   parameter int TICK_CYC = `GHL_CLK_HZ / `GHL_TICK_HZ
) (
   input  wire logic                       clk_i,
   input  wire logic                       sys_rst_i,
   input  wire logic                       smbus_clock_pin_i,
   output logic                            smbus_clock_pin_o,
   output logic                            smbus_clock_pin_oe_o,
   input  wire logic                       smbus_data_pin_i,
   output logic                            smbus_data_pin_o,
   output logic                            smbus_data_pin_oe_o,
   input  wire logic                       sw_pin_i,
   output logic                            sw_pin_o,
   output logic                            sw_pin_oe_o,
   input  wire ghl_pkg::ghl_smb_ctl_type   smb_ctl_i,
   input  wire ghl_pkg::ghl_meas_mode_type meas_mode_i,
   input  wire logic                       rd_cmd_done_i,
   input  wire logic                       tx_valid_i,
   input  wire logic                       tx_bit_i,
   output logic                            bus_start_o,
   output logic                            bus_stop_o,
   output logic                            bus_active_o,
   output logic                            timeout_o,
   output logic                            idle_reset_o,
   output logic                            bus_idle_o,
   output logic                            rate_err_o,
   output logic                            tx_ready_o,
   output logic                            tx_done_o,
   output logic                            rx_valid_o,
   output logic                            rx_bit_o,
   output logic                            meas_start_o,
   output logic                            rate_forecast_run_o
);

   localparam int CW = `GHL_CYC_W;
   localparam int MW = `GHL_MS_W;
   localparam int CLK_MHZ   = `GHL_CLK_HZ / 1000000;
   localparam int TOUT_T    = `GHL_TOUT_MS * `GHL_TICK_HZ / 1000;
   localparam int IDRST_T   = `GHL_IDLE_RST_MS * `GHL_TICK_HZ / 1000;
   localparam int SEXT_T    = `GHL_SEXT_MS * `GHL_TICK_HZ / 1000;
   localparam int MEXT_T    = `GHL_MEXT_MS * `GHL_TICK_HZ / 1000;
   localparam int BASE_T    = `GHL_MEAS_BASE_MS * `GHL_TICK_HZ / 1000;
   localparam int MAXI_T    = `GHL_MEAS_MAX_MS * `GHL_TICK_HZ / 1000;
   localparam int FCADD_T   = `GHL_FC_ADD_MS * `GHL_TICK_HZ / 1000;
   localparam int FCPER_T   = `GHL_FC_PER_MS * `GHL_TICK_HZ / 1000;
   localparam int IDLE_C    = `GHL_IDLE_US * CLK_MHZ;
   localparam int PMIN_C    = `GHL_CLK_HZ / (`GHL_SLV_FMAX_KHZ * 1000);
   localparam int HALF_C    = `GHL_CLK_HZ / (2 * `GHL_MST_HZ);
   localparam int START_C   = `GHL_SW_START_US * CLK_MHZ;
   localparam int B0_C      = `GHL_SW_B0_US * CLK_MHZ;
   localparam int CELL_C    = `GHL_SW_CELL_US * CLK_MHZ;
   localparam int RSP_C     = `GHL_SW_RSP_US * CLK_MHZ;
   localparam int RXS_C     = `GHL_SW_RXS_US * CLK_MHZ;

   ghl_pkg::ghl_state_type st_r;
   ghl_pkg::ghl_state_type st_nxt;
   logic [2:0]             pins_s;
   logic                   scl_s;
   logic                   sda_s;
   logic                   hdq_s;

   ////////////////////////////////////////////////////////////////////////////
   // pins come from outside the clock domain
   ghl_sync #(.W(3)) u_sync (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .d_i       ({smbus_clock_pin_i, smbus_data_pin_i, sw_pin_i}),
      .q_o       (pins_s)
   );
   assign scl_s = pins_s[2];
   assign sda_s = pins_s[1];
   assign hdq_s = pins_s[0];

   ////////////////////////////////////////////////////////////////////////////
   // next state of everything
   always_comb begin
      logic abort;
      logic host_fall;
      logic [MW-1:0] ival;
      abort     = 1'b0;
      host_fall = st_r.hdq_p & ~hdq_s & ~st_r.hdq_oe;
      ival      = '0;
      st_nxt    = st_r;
      st_nxt.scl_p    = scl_s;
      st_nxt.sda_p    = sda_s;
      st_nxt.hdq_p    = hdq_s;
      st_nxt.pin_lo   = 1'b0;
      st_nxt.start    = 1'b0;
      st_nxt.stop     = 1'b0;
      st_nxt.tout     = 1'b0;
      st_nxt.idrst    = 1'b0;
      st_nxt.rate_err = 1'b0;
      st_nxt.tx_done  = 1'b0;
      st_nxt.rx_valid = 1'b0;
      st_nxt.meas     = 1'b0;
      st_nxt.fc_run   = 1'b0;
      // millisecond tick divider
      st_nxt.tick = (st_r.tcnt == (`GHL_TICK_W)'(TICK_CYC - 1));
      st_nxt.tcnt = st_nxt.tick ? '0 : st_r.tcnt + 1'b1;

      // start and stop: data edge while the clock stays high
      if (scl_s && st_r.scl_p && st_r.sda_p && !sda_s) begin
         st_nxt.start   = 1'b1;
         st_nxt.act     = 1'b1;
         st_nxt.lock    = 1'b0;
         st_nxt.sext_ms = '0;
         st_nxt.mext_ms = '0;
      end else if (scl_s && st_r.scl_p && !st_r.sda_p && sda_s) begin
         st_nxt.stop = 1'b1;
         st_nxt.act  = 1'b0;
      end

      // clock-low watchdog; limit sits inside the 25..35 ms window
      if (scl_s) begin
         st_nxt.low_ms = '0;
      end else if (st_r.tick && st_r.low_ms != MW'(TOUT_T)) begin
         st_nxt.low_ms = st_r.low_ms + 1'b1;
         if (st_nxt.low_ms == MW'(TOUT_T) && st_r.act) begin
            st_nxt.tout = 1'b1;
            abort       = 1'b1;
         end
      end

      // clock stuck high ends any transaction in flight
      if (!scl_s || st_nxt.start) begin
         st_nxt.high_ms = '0; // a start restarts the count, else a long idle masks it
      end else if (st_r.tick && st_r.high_ms != MW'(IDRST_T)) begin
         st_nxt.high_ms = st_r.high_ms + 1'b1;
         if (st_nxt.high_ms == MW'(IDRST_T) && st_r.act) begin
            st_nxt.idrst = 1'b1;
            abort        = 1'b1;
         end
      end

      // idle needs an unbroken high stretch
      if (!scl_s) begin
         st_nxt.hus = '0;
      end else if (st_r.hus != CW'(IDLE_C)) begin
         st_nxt.hus = st_r.hus + 1'b1;
      end
      st_nxt.idle = scl_s && (st_nxt.hus == CW'(IDLE_C));

      // rising-edge spacing; only too-fast is flagged since stretching slows
      if (scl_s && !st_r.scl_p) begin
         st_nxt.per = '0;
         if (st_r.act && st_r.per < CW'(PMIN_C - 1)) begin
            st_nxt.rate_err = 1'b1;
         end
      end else if (st_r.per != {CW{1'b1}}) begin
         st_nxt.per = st_r.per + 1'b1;
      end

      // slave stretch budget, counted while we hold the line
      if (st_r.slv_drv && st_r.tick) begin
         st_nxt.sext_ms = st_r.sext_ms + 1'b1;
      end
      st_nxt.slv_drv = st_nxt.act && !st_nxt.lock && smb_ctl_i.slv_hold && !smb_ctl_i.mst_en
                       && (!scl_s || st_r.slv_drv) && st_nxt.sext_ms < MW'(SEXT_T);

      // master clock generator
      case (st_r.mst)
         ghl_pkg::MS_IDLE: begin
            st_nxt.mcnt = '0;
            if (smb_ctl_i.mst_en && smb_ctl_i.mst_run && !st_r.lock) begin
               st_nxt.mst = ghl_pkg::MS_LOW;
            end
         end
         ghl_pkg::MS_LOW: begin
            if (st_r.mcnt < CW'(HALF_C - 1)) begin
               st_nxt.mcnt = st_r.mcnt + 1'b1;
            end else if (smb_ctl_i.mst_hold && st_r.mext_ms < MW'(MEXT_T)) begin
               if (st_r.tick) begin
                  st_nxt.mext_ms = st_r.mext_ms + 1'b1;
               end
            end else begin
               st_nxt.mst  = ghl_pkg::MS_HIGH;
               st_nxt.mcnt = '0;
            end
         end
         ghl_pkg::MS_HIGH: begin
            if (!scl_s) begin
               st_nxt.mcnt = '0; // a slave is stretching: wait it out
            end else if (st_r.mcnt == CW'(HALF_C - 1)) begin
               st_nxt.mcnt = '0;
               st_nxt.mst  = (smb_ctl_i.mst_en && smb_ctl_i.mst_run) ? ghl_pkg::MS_LOW : ghl_pkg::MS_IDLE;
            end else begin
               st_nxt.mcnt = st_r.mcnt + 1'b1;
            end
         end
         default: begin
            st_nxt.mst = ghl_pkg::MS_IDLE;
         end
      endcase

      // abort releases both lines until the next start
      if (abort) begin
         st_nxt.act     = 1'b0;
         st_nxt.lock    = 1'b1;
         st_nxt.mst     = ghl_pkg::MS_IDLE;
         st_nxt.slv_drv = 1'b0;
      end
      st_nxt.scl_oe = st_nxt.slv_drv || (st_nxt.mst == ghl_pkg::MS_LOW);
      st_nxt.sda_oe = smb_ctl_i.sda_drive && st_nxt.act && !st_nxt.lock;

      // single-wire bit cells sent to the host
      if (st_r.sw == ghl_pkg::SW_START || st_r.sw == ghl_pkg::SW_DATA || st_r.sw == ghl_pkg::SW_REST) begin
         st_nxt.swcnt = st_r.swcnt + 1'b1;
      end
      case (st_r.sw)
         ghl_pkg::SW_IDLE: begin
            st_nxt.swcnt = '0;
            if (rd_cmd_done_i) begin
               st_nxt.sw = ghl_pkg::SW_WAIT;
            end
         end
         ghl_pkg::SW_WAIT: begin
            st_nxt.swcnt = st_r.swcnt + 1'b1;
            if (st_r.swcnt == CW'(RSP_C - 1)) begin
               st_nxt.sw       = ghl_pkg::SW_READY;
               st_nxt.swcnt    = '0;
               st_nxt.tx_ready = 1'b1;
            end
         end
         ghl_pkg::SW_READY: begin
            if (tx_valid_i) begin
               st_nxt.sw       = ghl_pkg::SW_START;
               st_nxt.swbit    = tx_bit_i;
               st_nxt.tx_ready = 1'b0;
            end else if (host_fall) begin
               st_nxt.sw       = ghl_pkg::SW_IDLE; // host took the line back
               st_nxt.tx_ready = 1'b0;
            end
         end
         ghl_pkg::SW_START: begin
            if (st_r.swcnt == CW'(START_C - 1)) begin
               st_nxt.sw = ghl_pkg::SW_DATA;
            end
         end
         ghl_pkg::SW_DATA: begin
            if (st_r.swcnt == CW'(B0_C - 1)) begin
               st_nxt.sw = ghl_pkg::SW_REST;
            end
         end
         ghl_pkg::SW_REST: begin
            if (st_r.swcnt == CW'(CELL_C - 1)) begin
               st_nxt.sw       = ghl_pkg::SW_READY;
               st_nxt.swcnt    = '0;
               st_nxt.tx_done  = 1'b1;
               st_nxt.tx_ready = 1'b1;
            end
         end
         default: begin
            st_nxt.sw = ghl_pkg::SW_IDLE;
         end
      endcase
      st_nxt.hdq_oe = (st_nxt.sw == ghl_pkg::SW_START) || (st_nxt.sw == ghl_pkg::SW_DATA && !st_nxt.swbit);

      // host cells: a falling edge outside our own sent cells starts one, data sampled mid-cell
      if (host_fall && st_r.sw != ghl_pkg::SW_START && st_r.sw != ghl_pkg::SW_DATA
          && st_r.sw != ghl_pkg::SW_REST) begin
         st_nxt.rxon  = 1'b1;
         st_nxt.rxcnt = '0;
      end else if (st_r.rxon) begin
         st_nxt.rxcnt = st_r.rxcnt + 1'b1;
         if (st_r.rxcnt == CW'(RXS_C - 1)) begin
            st_nxt.rxon     = 1'b0; // next fall only after the cell ends
            st_nxt.rx_valid = 1'b1;
            st_nxt.rx_bit   = hdq_s;
         end
      end

      // measurement schedule; forecast request set wins over the clear
      ival = MW'(BASE_T);
      if (meas_mode_i.comp_end_of_discharge_voltage && meas_mode_i.energy_units_mode && meas_mode_i.max_rate) begin
         ival = MW'(MAXI_T);
      end
      if (st_r.fc_due) begin
         ival = ival + MW'(FCADD_T);
      end
      if (st_r.tick) begin
         st_nxt.meas_ms = st_r.meas_ms + 1'b1;
         st_nxt.fc_ms   = st_r.fc_ms + 1'b1;
         if (st_nxt.meas_ms >= ival) begin
            st_nxt.meas    = 1'b1;
            st_nxt.fc_run  = st_r.fc_due;
            st_nxt.fc_due  = 1'b0;
            st_nxt.meas_ms = '0;
         end
         if (st_r.fc_ms == MW'(FCPER_T - 1)) begin
            st_nxt.fc_ms  = '0;
            st_nxt.fc_due = 1'b1;
         end
      end
      if (meas_mode_i.rate_forecast_req) begin
         st_nxt.fc_due = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register; lines start released, bus locked until a start
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_r       <= '0;
         st_r.scl_p <= `GHL_LINE_IDLE;
         st_r.sda_p <= `GHL_LINE_IDLE;
         st_r.hdq_p <= `GHL_LINE_IDLE;
         st_r.lock  <= 1'b1;
         st_r.mst   <= ghl_pkg::MS_IDLE;
         st_r.sw    <= ghl_pkg::SW_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs straight from the state register
   assign smbus_clock_pin_o    = st_r.pin_lo;
   assign smbus_clock_pin_oe_o = st_r.scl_oe;
   assign smbus_data_pin_o     = st_r.pin_lo;
   assign smbus_data_pin_oe_o  = st_r.sda_oe;
   assign sw_pin_o             = st_r.pin_lo;
   assign sw_pin_oe_o          = st_r.hdq_oe;
   assign bus_start_o          = st_r.start;
   assign bus_stop_o           = st_r.stop;
   assign bus_active_o         = st_r.act;
   assign timeout_o            = st_r.tout;
   assign idle_reset_o         = st_r.idrst;
   assign bus_idle_o           = st_r.idle;
   assign rate_err_o           = st_r.rate_err;
   assign tx_ready_o           = st_r.tx_ready;
   assign tx_done_o            = st_r.tx_done;
   assign rx_valid_o           = st_r.rx_valid;
   assign rx_bit_o             = st_r.rx_bit;
   assign meas_start_o         = st_r.meas;
   assign rate_forecast_run_o  = st_r.fc_run;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_cell_end;
      st_r.sw == ghl_pkg::SW_REST ##1 st_r.sw == ghl_pkg::SW_READY;
   endsequence
   sequence s_start_end;
      st_r.sw == ghl_pkg::SW_START ##1 st_r.sw == ghl_pkg::SW_DATA;
   endsequence
   sequence s_rsp_end;
      st_r.sw == ghl_pkg::SW_WAIT ##1 st_r.sw == ghl_pkg::SW_READY;
   endsequence

   chk_rate_fast: assert property (st_r.rate_err |-> $past(st_r.per) < CW'(PMIN_C - 1))
      else $error("rate error without a short clock period");
   chk_mst_half: assert property (st_r.mst == ghl_pkg::MS_HIGH && $past(st_r.mst) == ghl_pkg::MS_LOW
      |-> $past(st_r.mcnt) == CW'(HALF_C - 1)) else $error("master low phase not one half period");
   chk_tout_abort: assert property (st_r.tout |-> st_r.low_ms == MW'(TOUT_T) && st_r.lock && !st_r.act)
      else $error("timeout without full clock-low limit");
   chk_idle_reset: assert property (st_r.idrst |-> st_r.high_ms == MW'(IDRST_T) && !st_r.act)
      else $error("idle reset before 50 ms high");
   chk_bus_idle: assert property (st_r.idle |-> st_r.hus == CW'(IDLE_C) && $past(scl_s))
      else $error("bus idle before 50 us high");
   chk_slave_budget: assert property (st_r.slv_drv |-> st_r.sext_ms < MW'(SEXT_T))
      else $error("slave stretch beyond budget");
   chk_master_budget: assert property (st_r.mext_ms <= MW'(MEXT_T))
      else $error("master stretch beyond budget");
   chk_cell_len: assert property (s_cell_end |-> $past(st_r.swcnt) == CW'(CELL_C - 1) && st_r.tx_done)
      else $error("sent bit cell of wrong length");
   chk_start_low: assert property (s_start_end |-> $past(st_r.hdq_oe)
      && $past(st_r.swcnt) == CW'(START_C - 1))
      else $error("start low pulse too short");
   chk_rsp_delay: assert property (s_rsp_end |-> $past(st_r.swcnt) == CW'(RSP_C - 1))
      else $error("read response delay off");
   chk_meas_ival: assert property (st_r.meas |-> $past(st_r.meas_ms) + 1 == BASE_T
      || $past(st_r.meas_ms) + 1 == MAXI_T || $past(st_r.meas_ms) + 1 == MAXI_T + FCADD_T
      || $past(st_r.meas_ms) + 1 == BASE_T + FCADD_T) else $error("measurement interval off");
   chk_release: assert property (st_r.tout |-> !st_r.scl_oe && !st_r.sda_oe ##1 !st_r.scl_oe [*2])
      else $error("line driven after abort");

endmodule

`default_nettype wire

// file: design/ghl_pkg.sv
/*
 * Types of the gauge host-link timing block: state enums, carrier structs
 * and the single packed state record. Assumes ghl_defines.svh is on the path.
 */
`include "ghl_defines.svh"

package ghl_pkg;

   typedef enum logic [1:0] {MS_IDLE, MS_LOW, MS_HIGH} ghl_mst_type;

   typedef enum logic [2:0] {SW_IDLE, SW_WAIT, SW_READY, SW_START, SW_DATA, SW_REST} ghl_sw_type;

   // smbus requests from the gauge core
   typedef struct packed {
      logic mst_en;
      logic mst_run;
      logic mst_hold;
      logic slv_hold;
      logic sda_drive;
   } ghl_smb_ctl_type;

   // operating mode seen by the measurement scheduler
   typedef struct packed {
      logic comp_end_of_discharge_voltage;
      logic energy_units_mode;
      logic max_rate;
      logic rate_forecast_req;
   } ghl_meas_mode_type;

   typedef struct packed {
      logic                   scl_p;
      logic                   sda_p;
      logic                   hdq_p;
      logic [`GHL_TICK_W-1:0] tcnt;
      logic                   tick;
      logic                   act;
      logic                   lock;
      logic [`GHL_MS_W-1:0]   low_ms;
      logic [`GHL_MS_W-1:0]   high_ms;
      logic [`GHL_MS_W-1:0]   sext_ms;
      logic [`GHL_MS_W-1:0]   mext_ms;
      logic [`GHL_CYC_W-1:0]  hus;
      logic [`GHL_CYC_W-1:0]  per;
      ghl_mst_type            mst;
      logic [`GHL_CYC_W-1:0]  mcnt;
      ghl_sw_type             sw;
      logic [`GHL_CYC_W-1:0]  swcnt;
      logic                   swbit;
      logic                   rxon;
      logic [`GHL_CYC_W-1:0]  rxcnt;
      logic [`GHL_MS_W-1:0]   meas_ms;
      logic [`GHL_MS_W-1:0]   fc_ms;
      logic                   fc_due;
      logic                   pin_lo;
      logic                   slv_drv;
      logic                   scl_oe;
      logic                   sda_oe;
      logic                   hdq_oe;
      logic                   start;
      logic                   stop;
      logic                   tout;
      logic                   idrst;
      logic                   idle;
      logic                   rate_err;
      logic                   tx_ready;
      logic                   tx_done;
      logic                   rx_valid;
      logic                   rx_bit;
      logic                   meas;
      logic                   fc_run;
   } ghl_state_type;

endpackage

// file: design/ghl_sync.sv
/*
 * Two-flop synchroniser, one stage pair per bit.
 * Assumes asynchronous inputs; lines idle high after reset.
 */
`timescale 1ns/1ns
`default_nettype none
`include "ghl_defines.svh"

module ghl_sync #(
   parameter int W = 3
) (
   input  wire logic         clk_i,
   input  wire logic         sys_rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   logic [W-1:0] meta_r;

   ////////////////////////////////////////////////////////////////////////////
   // first stage is read only by the second
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               meta_r[g] <= `GHL_LINE_IDLE;
               q_o[g]    <= `GHL_LINE_IDLE;
            end else begin
               meta_r[g] <= d_i[g];
               q_o[g]    <= meta_r[g];
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

// file: test/ghl_host_model.sv
/* single-wire host model: writes bit cells, decodes the gauge's cells.
   assumes a pulled-up line resolved by the bench. */
`timescale 1ns/1ns
`default_nettype none
module ghl_host_model (
   input  wire logic clk_i,
   input  wire logic line_i,
   input  wire logic dev_oe_i,
   input  wire logic wr_go_i,
   input  wire logic wr_bit_i,
   output logic      host_oe_o,
   output logic      got_o,
   output logic      got_ok_o,
   output logic      got_bit_o
);
   int   w  = 0;
   int   lo = 0;
   int   n  = 0;
   logic ok = 1'b0;
   initial {host_oe_o, got_o, got_ok_o, got_bit_o} = 4'h0;
   // 200 us write cell, released line floats back up to the pull-up level
   always @(posedge clk_i) begin
      if (wr_go_i) begin
         w <= 2000;
         lo <= wr_bit_i ? 10 : 1500;
      end else if (w > 0) begin
         w <= w - 1;
      end
      host_oe_o <= w > 2000 - lo;
   end
   // start must still be low at 32 us; data is read at 80 us like a real host
   always @(posedge clk_i) begin
      got_o <= 1'b0;
      if (n == 0 && dev_oe_i) n <= 1;
      else if (n > 0) n <= (n == 1500) ? 0 : n + 1;
      if (n == 319) ok <= !line_i;
      if (n == 800) begin
         got_o <= 1'b1;
         got_ok_o <= ok;
         got_bit_o <= line_i;
      end
   end
endmodule
`default_nettype wire

// file: test/test_gauge_host_link_timing.sv
/* bench: single-wire cells, smbus abort, measurement interval.
   assumes the host model and a 10-cycle millisecond tick. */
`timescale 1ns/1ns
`default_nettype none
module test_gauge_host_link_timing;
   typedef struct {int lo; int hi;} ghl_note_type;
   ghl_note_type q[$];
   logic clk_i = 1'b0, sys_rst_i = 1'b1, scl = 1'b1, sda = 1'b1, rd = 1'b0, tv = 1'b0, tx_bit = 1'b0;
   logic wr_go = 1'b0, wr_bit = 1'b0, watch = 1'b0, idrst;
   ghl_pkg::ghl_smb_ctl_type ctl = '0;
   ghl_pkg::ghl_meas_mode_type mode = '0;
   logic scl_oe, sda_oe, sw_oe, h_oe, h_got, h_ok, h_bit, tx_ready, tx_done, rx_valid, rx_bit, bstart, tout, rerr, meas;
   int cyc = 0, t_mark = 0, t_prev = 0, num_errors = 0, comparisons = 0;
   always #50 clk_i = !clk_i;
   ghl_link_timing #(.TICK_CYC(10)) u_ghl_link_timing (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .smbus_clock_pin_i(scl & !scl_oe), .smbus_clock_pin_o(), .smbus_clock_pin_oe_o(scl_oe),
      .smbus_data_pin_i(sda & !sda_oe), .smbus_data_pin_o(), .smbus_data_pin_oe_o(sda_oe),
      .sw_pin_i(!(sw_oe | h_oe)), .sw_pin_o(), .sw_pin_oe_o(sw_oe), .smb_ctl_i(ctl), .meas_mode_i(mode),
      .rd_cmd_done_i(rd), .tx_valid_i(tv), .tx_bit_i(tx_bit), .bus_start_o(bstart), .bus_stop_o(),
      .bus_active_o(), .timeout_o(tout), .idle_reset_o(idrst), .bus_idle_o(), .rate_err_o(rerr),
      .tx_ready_o(tx_ready), .tx_done_o(tx_done), .rx_valid_o(rx_valid), .rx_bit_o(rx_bit),
      .meas_start_o(meas), .rate_forecast_run_o());
   ghl_host_model u_ghl_host_model (.clk_i(clk_i), .line_i(!(sw_oe | h_oe)), .dev_oe_i(sw_oe),
      .wr_go_i(wr_go), .wr_bit_i(wr_bit), .host_oe_o(h_oe), .got_o(h_got), .got_ok_o(h_ok), .got_bit_o(h_bit));
   ////////////////////////////////////////////////////////////////////////////
   task automatic note(int lo, int hi);
      q.push_back('{lo, hi});
   endtask
   // an event with no note left is a stray output, so it fails too
   task automatic check(logic [31:0] act);
      comparisons++;
      if (q.size() == 0 || ((act >= q[0].lo && act <= q[0].hi) !== 1'b1)) begin
         num_errors++;
         $display("FAIL %0t result %0d off its expected range", $time, act);
      end
      if (q.size() > 0) void'(q.pop_front());
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if ($rose(tx_ready) && !tx_done) check(cyc - t_mark);
      if (tx_done) check(cyc - t_mark);
      if (h_got) check({h_ok, h_bit});
      if (rx_valid) check(rx_bit);
      if (bstart || rerr) check(1);
      if (tout) check(cyc - t_mark);
      if (idrst) check(cyc - t_mark);
      if (scl_oe || sda_oe) check(99);
      if (meas && watch) begin
         if (t_prev > 0) check(cyc - t_prev);
         t_prev <= cyc;
      end
   end
   task automatic sw_read(logic b);
      note(1900, 3200);
      rd <= 1'b1;
      t_mark <= cyc;
      @(posedge clk_i) rd <= 1'b0;
      for (int i = 0; i < 4000 && tx_ready !== 1'b1; i++) @(posedge clk_i);
      note(2 + b, 2 + b);
      note(1900, 2500);
      tv <= 1'b1;
      tx_bit <= b;
      t_mark <= cyc;
      @(posedge clk_i) tv <= 1'b0;
      for (int i = 0; i < 3000 && tx_done !== 1'b1; i++) @(posedge clk_i);
   endtask
   task automatic stop_test();
      if (q.size() > 0) begin
         num_errors++;
         $display("FAIL %0t expected result never came", $time);
      end
      if (num_errors == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic b;
      int r;
      void'($urandom(68382));
      repeat (12) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      b = $urandom % 2;
      for (int i = 0; i < 2; i++) begin
         @(posedge clk_i);
         sw_read(b ^ i[0]);
         note(b ^ i[0], b ^ i[0]);
         wr_go <= 1'b1;
         wr_bit <= b ^ i[0];
         @(posedge clk_i) wr_go <= 1'b0;
         repeat (2100) @(posedge clk_i);
      end
      // start, then two rising clock edges 800 ns apart, then a stuck-low clock
      note(1, 1);
      note(1, 1);
      sda <= 1'b0;
      repeat (50) @(posedge clk_i);
      repeat (4) begin
         repeat (4) @(posedge clk_i);
         scl <= !scl;
      end
      @(posedge clk_i) scl <= 1'b0;
      note(250, 350);
      t_mark <= cyc;
      for (int i = 0; i < 600 && tout !== 1'b1; i++) @(posedge clk_i);
      ctl <= '1;
      repeat (100) @(posedge clk_i);
      // fresh start, then a clock left high past the idle-reset limit
      ctl <= '0;
      scl <= 1'b1;
      repeat (5) @(posedge clk_i);
      sda <= 1'b1;
      repeat (5) @(posedge clk_i);
      note(1, 1);
      note(450, 560);
      sda <= 1'b0;
      t_mark <= cyc;
      for (int i = 0; i < 900 && idrst !== 1'b1; i++) @(posedge clk_i);
      ctl <= 5'h03;
      r = $urandom % 2;
      mode <= '{1'b1, 1'b1, r[0], 1'b0};
      note((r ? 2500 : 2000) * 10 - 10, (r ? 2500 : 2000) * 10 + 10);
      watch <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         @(posedge clk_i);
         for (int i = 0; i < 30000 && meas !== 1'b1; i++) @(posedge clk_i);
      end
      // let the monitor take the last pulse before the verdict
      @(posedge clk_i) watch <= 1'b0;
      stop_test();
   end
   initial begin
      #10000000;
      num_errors++;
      $display("FAIL %0t run did not finish", $time);
      stop_test();
   end
endmodule
`default_nettype wire
